//--- logic/fsg_pkg.sv
// Package of constants for the flash sector write guard host controller.
package fsg_pkg;
  // Wishbone register word offsets (byte addresses).
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_ADDR = 8'h04;
  localparam logic [7:0] REG_DATA = 8'h08;
  localparam logic [7:0] REG_STAT = 8'h0c;
  localparam logic [7:0] REG_RDAT = 8'h10;
  // Control register fields.
  localparam int CTRL_GO      = 0;
  localparam int CTRL_READ    = 1;
  localparam int CTRL_WP_N    = 2;
  localparam int CTRL_HV      = 3;
  localparam int CTRL_RESET_N = 4;
  localparam int CTRL_UNLOCK  = 5;
  localparam logic [31:0] CTRL_RESET_VAL = 32'h0000_0014;
  // Status register fields.
  localparam int STAT_BUSY  = 0;
  localparam int STAT_REFUS = 1;
  localparam int STAT_IND   = 2;
  localparam int STAT_PWROK = 3;
  // Command sequence words.
  localparam logic [21:0] UNLOCK_ADDR1 = 22'h000555;
  localparam logic [21:0] UNLOCK_ADDR2 = 22'h0002aa;
  localparam logic [15:0] UNLOCK_DATA1 = 16'h00aa;
  localparam logic [15:0] UNLOCK_DATA2 = 16'h0055;
  localparam logic [15:0] PROT_YES = 16'h0001;
  // Strobe timing: each phase held well above the 5 ns glitch floor.
  localparam int CLK_PERIOD_PS = 8000;
  localparam int STROBE_NS     = 70;
  localparam int STROBE_CYC    = (STROBE_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int GLITCH_NS     = 5;
  localparam int GLITCH_CYC    = (GLITCH_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  typedef enum logic [1:0] {BUS_IDLE, BUS_SETUP, BUS_STROBE, BUS_HOLD} fsg_bus_t;
endpackage

//--- logic/fsg_cycle_if.sv
// Interface carrying single flash bus cycle requests between modules.
interface fsg_cycle_if;
  logic        req;
  logic        rd;
  logic [21:0] addr;
  logic [15:0] wdata;
  logic [15:0] rdata;
  logic        done;
  modport master (output req, output rd, output addr, output wdata,
                  input rdata, input done);
  modport slave  (input req, input rd, input addr, input wdata,
                  output rdata, output done);
endinterface

//--- logic/fsg_cycle.sv
// One asynchronous flash bus cycle: read or write with held strobes.
module fsg_cycle
(
  // Clock and reset
  input  wire logic  clk,
  input  wire logic  rst,
  // Request side
  fsg_cycle_if.slave cyc,
  // Flash strobes and bus
  output logic       ce_n,
  output logic       we_n,
  output logic       oe_n,
  output logic [21:0] addr,
  output logic [15:0] dq_o,
  output logic       dq_oe,
  input  wire logic [15:0] dq_i
);
  fsg_pkg::fsg_bus_t st_r, st_nxt;
  logic [7:0]  cnt_r, cnt_nxt;
  logic        rd_r, rd_nxt;
  logic [21:0] a_r, a_nxt;
  logic [15:0] d_r, d_nxt, q_r, q_nxt;
  logic        done_r, done_nxt;
  localparam logic [7:0] PHASE = 8'(fsg_pkg::STROBE_CYC);

  always_comb
  begin
    st_nxt = st_r;
    cnt_nxt = cnt_r;
    rd_nxt = rd_r;
    a_nxt = a_r;
    d_nxt = d_r;
    q_nxt = q_r;
    done_nxt = 1'b0;
    unique case (st_r)
      fsg_pkg::BUS_IDLE:
        if (cyc.req)
        begin
          rd_nxt = cyc.rd;
          a_nxt = cyc.addr;
          d_nxt = cyc.wdata;
          cnt_nxt = PHASE;
          st_nxt = fsg_pkg::BUS_SETUP;
        end
      fsg_pkg::BUS_SETUP:
      begin
        cnt_nxt = PHASE;
        st_nxt = fsg_pkg::BUS_STROBE;
      end
      fsg_pkg::BUS_STROBE:
        if (cnt_r == 8'h00)
        begin
          if (rd_r)
            q_nxt = dq_i;
          cnt_nxt = PHASE;
          st_nxt = fsg_pkg::BUS_HOLD;
        end
        else
          cnt_nxt = cnt_r - 8'h01;
      fsg_pkg::BUS_HOLD:
        if (cnt_r == 8'h00)
        begin
          done_nxt = 1'b1;
          st_nxt = fsg_pkg::BUS_IDLE;
        end
        else
          cnt_nxt = cnt_r - 8'h01;
    endcase
  end

  always_ff @(posedge clk or posedge rst)
    if (rst)
    begin
      st_r <= fsg_pkg::BUS_IDLE;
      cnt_r <= 8'h00;
      rd_r <= 1'b1;
      a_r <= 22'h000000;
      d_r <= 16'h0000;
      q_r <= 16'h0000;
      done_r <= 1'b0;
    end
    else
    begin
      st_r <= st_nxt;
      cnt_r <= cnt_nxt;
      rd_r <= rd_nxt;
      a_r <= a_nxt;
      d_r <= d_nxt;
      q_r <= q_nxt;
      done_r <= done_nxt;
    end

  // Write only with chip select and write strobe low and output strobe high; the
  // strobe stays low for many cycles so the cycle is never mistaken for noise.
  assign ce_n = (st_r == fsg_pkg::BUS_IDLE);
  assign we_n = !(st_r == fsg_pkg::BUS_STROBE && !rd_r);
  assign oe_n = !(st_r == fsg_pkg::BUS_STROBE && rd_r);
  assign dq_oe = !rd_r && st_r != fsg_pkg::BUS_IDLE;
  assign addr = a_r;
  assign dq_o = d_r;
  assign cyc.rdata = q_r;
  assign cyc.done = done_r;
endmodule

//--- logic/fsg_host.sv
// Host controller driving a parallel NOR flash and its protection pins.
//
// Implementation choices: the Wishbone slave port and the register addresses.
module fsg_host
(
  // Clock and reset
  input  wire logic        CLOCK,
  input  wire logic        RST,
  // Wishbone slave
  input  wire logic        WB_CYC_I,
  input  wire logic        WB_STB_I,
  input  wire logic        WB_WE_I,
  input  wire logic [7:0]  WB_ADR_I,
  input  wire logic [3:0]  WB_SEL_I,
  input  wire logic [31:0] WB_DAT_I,
  output logic [31:0]      WB_DAT_O,
  output logic             WB_ACK_O,
  // Flash bus
  output logic             FL_CE_N,
  output logic             FL_WE_N,
  output logic             FL_OE_N,
  output logic [21:0]      FL_ADDR,
  output logic [15:0]      FL_DQ_O,
  output logic             FL_DQ_OE,
  input  wire logic [15:0] FL_DQ_I,
  // Protection and reset pins, supply-good input
  output logic             FL_WRITE_PROTECT_N,
  output logic             FL_RESET_N,
  output logic             FL_RESET_HIGH_VOLTAGE,
  input  wire logic        FL_SUPPLY_OK
);
  fsg_cycle_if cyc ();

  logic [31:0] ctrl_r, ctrl_nxt;
  logic [21:0] addr_r, addr_nxt;
  logic [15:0] data_r, data_nxt;
  logic [15:0] rdat_r, rdat_nxt;
  logic        refused_r, refused_nxt;
  logic        ack_r, ack_nxt;
  logic [31:0] dat_o_r, dat_o_nxt;
  logic [1:0]  step_r, step_nxt;
  logic        busy_r, busy_nxt;
  logic        pwr_s1_r, pwr_s2_r;
  logic        wb_req;

  // Supply-good comes from a pin, so it is synchronised before use.
  always_ff @(posedge CLOCK or posedge RST)
    if (RST)
    begin
      pwr_s1_r <= 1'b0;
      pwr_s2_r <= 1'b0;
    end
    else
    begin
      pwr_s1_r <= FL_SUPPLY_OK;
      pwr_s2_r <= pwr_s1_r;
    end

  assign wb_req = WB_CYC_I && WB_STB_I && !ack_r;

  always_comb
  begin
    ctrl_nxt = ctrl_r;
    addr_nxt = addr_r;
    data_nxt = data_r;
    rdat_nxt = rdat_r;
    refused_nxt = refused_r;
    ack_nxt = wb_req;
    dat_o_nxt = dat_o_r;
    step_nxt = step_r;
    busy_nxt = busy_r;
    cyc.req = 1'b0;
    cyc.rd = ctrl_r[fsg_pkg::CTRL_READ];
    cyc.addr = addr_r;
    cyc.wdata = data_r;
    if (wb_req)
    begin
      dat_o_nxt = 32'h0000_0000;
      unique case (WB_ADR_I)
        fsg_pkg::REG_CTRL:
          if (WB_WE_I)
          begin
            if (WB_SEL_I[0])
              ctrl_nxt[7:0] = WB_DAT_I[7:0];
            // A new request while busy is dropped and flagged.
            if (WB_SEL_I[0] && WB_DAT_I[fsg_pkg::CTRL_GO])
            begin
              if (busy_r)
                refused_nxt = 1'b1;
              // While the supply is low the host starts no new write and abandons one under way; only a bus cycle already started runs to its end.
              else if (!pwr_s2_r && !WB_DAT_I[fsg_pkg::CTRL_READ])
                refused_nxt = 1'b1;
              else
              begin
                busy_nxt = 1'b1;
                step_nxt = WB_DAT_I[fsg_pkg::CTRL_UNLOCK] && !WB_DAT_I[fsg_pkg::CTRL_READ]
                         ? 2'h1 : 2'h3;
              end
            end
          end
          else
            dat_o_nxt = ctrl_r;
        fsg_pkg::REG_ADDR:
          if (WB_WE_I)
            addr_nxt = WB_DAT_I[21:0];
          else
            dat_o_nxt = {10'h000, addr_r};
        fsg_pkg::REG_DATA:
          if (WB_WE_I)
            data_nxt = WB_DAT_I[15:0];
          else
            dat_o_nxt = {16'h0000, data_r};
        fsg_pkg::REG_STAT:
          if (WB_WE_I)
          begin
            // Write one clears the refused flag.
            if (WB_DAT_I[fsg_pkg::STAT_REFUS])
              refused_nxt = 1'b0;
          end
          else
          begin
            dat_o_nxt[fsg_pkg::STAT_BUSY] = busy_r;
            dat_o_nxt[fsg_pkg::STAT_REFUS] = refused_r;
            // Indicator bit 7 of the last read: 1 factory locked, 0 customer.
            dat_o_nxt[fsg_pkg::STAT_IND] = rdat_r[7];
            dat_o_nxt[fsg_pkg::STAT_PWROK] = pwr_s2_r;
          end
        fsg_pkg::REG_RDAT:
          if (!WB_WE_I)
            // Protection query answers 01h protected, 00h unprotected.
            dat_o_nxt = {16'h0000, rdat_r};
        default:
          dat_o_nxt = 32'h0000_0000;
      endcase
    end
    // Sequencer: two unlock writes when UNLOCK is set on a write, then the payload cycle.
    if (busy_r)
    begin
      cyc.req = 1'b1;
      unique case (step_r)
        2'h1:
        begin
          cyc.rd = 1'b0;
          cyc.addr = fsg_pkg::UNLOCK_ADDR1;
          cyc.wdata = fsg_pkg::UNLOCK_DATA1;
        end
        2'h2:
        begin
          cyc.rd = 1'b0;
          cyc.addr = fsg_pkg::UNLOCK_ADDR2;
          cyc.wdata = fsg_pkg::UNLOCK_DATA2;
        end
        default:
        begin
          cyc.rd = ctrl_r[fsg_pkg::CTRL_READ];
          cyc.addr = addr_r;
          cyc.wdata = data_r;
        end
      endcase
      if (!cyc.rd && !pwr_s2_r)
      begin
        // Supply dropped mid-sequence: abandon it.
        cyc.req = 1'b0;
        busy_nxt = 1'b0;
        refused_nxt = 1'b1;
      end
      if (cyc.done)
      begin
        cyc.req = 1'b0;
        if (step_r == 2'h3)
        begin
          busy_nxt = 1'b0;
          if (ctrl_r[fsg_pkg::CTRL_READ])
            rdat_nxt = cyc.rdata;
        end
        else
          step_nxt = step_r + 2'h1;
      end
    end
    // The GO bit is a one-shot and never reads back set.
    ctrl_nxt[fsg_pkg::CTRL_GO] = 1'b0;
  end

  always_ff @(posedge CLOCK or posedge RST)
    if (RST)
    begin
      ctrl_r <= fsg_pkg::CTRL_RESET_VAL;
      addr_r <= 22'h000000;
      data_r <= 16'h0000;
      rdat_r <= 16'h0000;
      refused_r <= 1'b0;
      ack_r <= 1'b0;
      dat_o_r <= 32'h0000_0000;
      step_r <= 2'h3;
      busy_r <= 1'b0;
    end
    else
    begin
      ctrl_r <= ctrl_nxt;
      addr_r <= addr_nxt;
      data_r <= data_nxt;
      rdat_r <= rdat_nxt;
      refused_r <= refused_nxt;
      ack_r <= ack_nxt;
      dat_o_r <= dat_o_nxt;
      step_r <= step_nxt;
      busy_r <= busy_nxt;
    end

  fsg_cycle u_cycle
  (
    .clk   (CLOCK),
    .rst   (RST),
    .cyc   (cyc.slave),
    .ce_n  (FL_CE_N),
    .we_n  (FL_WE_N),
    .oe_n  (FL_OE_N),
    .addr  (FL_ADDR),
    .dq_o  (FL_DQ_O),
    .dq_oe (FL_DQ_OE),
    .dq_i  (FL_DQ_I)
  );

  assign WB_ACK_O = ack_r;
  assign WB_DAT_O = dat_o_r;
  // Protect pin low locks the outer boot sectors, also during unprotect.
  assign FL_WRITE_PROTECT_N = ctrl_r[fsg_pkg::CTRL_WP_N];
  // Pulsing reset low also drops the device out of secured mode.
  assign FL_RESET_N = ctrl_r[fsg_pkg::CTRL_RESET_N];
  // High voltage on reset is a separate qualifier for temporary unprotect.
  assign FL_RESET_HIGH_VOLTAGE = ctrl_r[fsg_pkg::CTRL_HV];
endmodule

//--- sim/fsg_host_checker.sv
// Checker of the host controller's bus handshake and flash strobe timing.
module fsg_host_checker
(
  // Clock and reset
  input wire logic        CLOCK,
  input wire logic        RST,
  // Watched ports
  input wire logic        WB_CYC_I,
  input wire logic        WB_STB_I,
  input wire logic        WB_ACK_O,
  input wire logic        FL_CE_N,
  input wire logic        FL_WE_N,
  input wire logic        FL_OE_N,
  input wire logic [21:0] FL_ADDR,
  input wire logic [15:0] FL_DQ_O,
  input wire logic        FL_DQ_OE,
  input wire logic        FL_SUPPLY_OK
);
  default clocking cb @(posedge CLOCK);
  endclocking
  default disable iff (RST);
  sequence s_we_held;
    !FL_WE_N [*8];
  endsequence
  sequence s_first_unlock;
    $fell(FL_WE_N) && FL_ADDR == fsg_pkg::UNLOCK_ADDR1 && FL_DQ_O == fsg_pkg::UNLOCK_DATA1;
  endsequence
  sequence s_second_unlock;
    $fell(FL_WE_N) && FL_ADDR == fsg_pkg::UNLOCK_ADDR2 && FL_DQ_O == fsg_pkg::UNLOCK_DATA2;
  endsequence
  chk_ack_one: assert property (WB_CYC_I && WB_STB_I && !WB_ACK_O |=> WB_ACK_O)
    else $error("ack not one cycle after request");
  chk_ack_pulse: assert property (WB_ACK_O |=> !WB_ACK_O)
    else $error("ack longer than one cycle");
  chk_write_legal: assert property (!FL_WE_N |-> !FL_CE_N && FL_OE_N && FL_DQ_OE)
    else $error("write strobe without select or with output enabled");
  chk_read_legal: assert property (!FL_OE_N |-> !FL_CE_N && FL_WE_N && !FL_DQ_OE)
    else $error("read strobe overlaps a write or a driven bus");
  chk_we_width: assert property ($fell(FL_WE_N) |-> s_we_held)
    else $error("write strobe too short");
  chk_oe_width: assert property ($fell(FL_OE_N) |-> (!FL_OE_N) [*8])
    else $error("output strobe too short");
  chk_addr_stable: assert property (!FL_WE_N && $past(!FL_WE_N) |-> $stable(FL_ADDR) && $stable(FL_DQ_O))
    else $error("address or data moved under write strobe");
  chk_supply_gate: assert property ($fell(FL_WE_N) |-> $past(FL_SUPPLY_OK, 4))
    else $error("write strobe with supply low");
  chk_unlock_order: assert property (s_first_unlock |-> ##[1:60] s_second_unlock)
    else $error("second unlock cycle missing");
endmodule

bind fsg_host fsg_host_checker u_chk (.CLOCK(CLOCK), .RST(RST), .WB_CYC_I(WB_CYC_I),
  .WB_STB_I(WB_STB_I), .WB_ACK_O(WB_ACK_O), .FL_CE_N(FL_CE_N), .FL_WE_N(FL_WE_N),
  .FL_OE_N(FL_OE_N), .FL_ADDR(FL_ADDR), .FL_DQ_O(FL_DQ_O), .FL_DQ_OE(FL_DQ_OE),
  .FL_SUPPLY_OK(FL_SUPPLY_OK));

//--- sim/fsg_flash_model.sv
// Behavioural model of the flash device on the far side of the host controller.
module fsg_flash_model
#(
  parameter bit          TOP_BOOT = 1'b0,
  parameter logic [21:0] PROT_LO  = 22'h010000,
  parameter logic [21:0] PROT_HI  = 22'h017fff
)
(
  // Strobes and bus
  input  wire logic        ce_n,
  input  wire logic        we_n,
  input  wire logic        oe_n,
  input  wire logic [21:0] addr,
  input  wire logic [15:0] dq_o,
  output logic      [15:0] dq_i,
  // Protection, reset and supply
  input  wire logic        wp_n,
  input  wire logic        reset_n,
  input  wire logic        hv,
  input  wire logic        supply_ok
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [15:0] mem [logic [21:0]];
  logic [15:0] last = 16'h0000;
  logic [1:0]  step = 2'd0;
  realtime     t_fall = 0.0;
  logic        outer;
  logic        locked;
  assign outer = TOP_BOOT ? (addr >= 22'h1fe000) : (addr < 22'h002000);
  assign locked = (outer && !wp_n) || (addr >= PROT_LO && addr <= PROT_HI && !hv);
  // A released bus shows the inverse of its last value so no stale word reads as valid.
  always @(*)
  begin
    if (!ce_n && !oe_n)
    begin
      dq_i = mem.exists(addr) ? mem[addr] : 16'hffff;
      last = dq_i;
    end
    else
      dq_i = ~last;
  end
  always @(negedge we_n)
    t_fall = $realtime;
  always @(negedge supply_ok or negedge reset_n)
    step = 2'd0;
  always @(posedge we_n)
  begin
    if (supply_ok && reset_n && !ce_n && oe_n && ($realtime - t_fall) >= 5.0)
    begin
      case (step)
        2'd0: step = (addr == fsg_pkg::UNLOCK_ADDR1 && dq_o == fsg_pkg::UNLOCK_DATA1) ? 2'd1 : 2'd0;
        2'd1: step = (addr == fsg_pkg::UNLOCK_ADDR2 && dq_o == fsg_pkg::UNLOCK_DATA2) ? 2'd2 : 2'd0;
        default:
        begin
          if (!locked)
            mem[addr] = dq_o & (mem.exists(addr) ? mem[addr] : 16'hffff);
          step = 2'd0;
        end
      endcase
    end
  end
endmodule

//--- sim/test_fsg_host.sv
// Self-checking bench for the flash host controller against a device model.
module test_fsg_host;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clock = 1'b0;
  logic        rst = 1'b1;
  logic        cyc = 1'b0;
  logic        stb = 1'b0;
  logic        we = 1'b0;
  logic [7:0]  adr = 8'h00;
  logic [31:0] wdat = 32'h0;
  logic        supply = 1'b1;
  logic [31:0] rdat;
  logic        ack;
  logic        ce_n;
  logic        we_n;
  logic        oe_n;
  logic [21:0] faddr;
  logic [15:0] fdq_o;
  logic [15:0] fdq_i;
  logic        wp_n;
  logic        reset_n;
  logic        hv;
  logic [15:0] shadow [logic [21:0]];
  integer      seed = 32'he75f;
  int          miscompares = 0;
  int          checks = 0;
  int          cycles = 0;
  always #4 clock = ~clock;
  fsg_host dut (.CLOCK(clock), .RST(rst), .WB_CYC_I(cyc), .WB_STB_I(stb), .WB_WE_I(we),
    .WB_ADR_I(adr), .WB_SEL_I(4'hf), .WB_DAT_I(wdat), .WB_DAT_O(rdat), .WB_ACK_O(ack),
    .FL_CE_N(ce_n), .FL_WE_N(we_n), .FL_OE_N(oe_n), .FL_ADDR(faddr), .FL_DQ_O(fdq_o),
    .FL_DQ_OE(), .FL_DQ_I(fdq_i), .FL_WRITE_PROTECT_N(wp_n), .FL_RESET_N(reset_n),
    .FL_RESET_HIGH_VOLTAGE(hv), .FL_SUPPLY_OK(supply));
  fsg_flash_model flash (.ce_n(ce_n), .we_n(we_n), .oe_n(oe_n), .addr(faddr), .dq_o(fdq_o),
    .dq_i(fdq_i), .wp_n(wp_n), .reset_n(reset_n), .hv(hv), .supply_ok(supply));
  task automatic final_report();
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
    checks++;
    if (got !== exp)
    begin
      miscompares++;
      $display("BAD %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d,
      output logic [31:0] q);
    @(posedge clock);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    // Only the bench-wide cycle limit may end this wait.
    do
    begin
      @(posedge clock);
    end while (ack !== 1'b1);
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
  endtask
  task automatic flash_op(input logic [21:0] a, input logic [15:0] d, input logic [5:0] ctl);
    logic [31:0] q;
    wb(1'b1, fsg_pkg::REG_ADDR, {10'h0, a}, q);
    wb(1'b1, fsg_pkg::REG_DATA, {16'h0, d}, q);
    wb(1'b1, fsg_pkg::REG_CTRL, {26'h0, ctl}, q);
    do
    begin
      wb(1'b0, fsg_pkg::REG_STAT, 32'h0, q);
    end while (q[fsg_pkg::STAT_BUSY] !== 1'b0);
  endtask
  // Control word: unlock, reset pin high, high voltage, protect pin, read, go.
  function automatic logic [15:0] expect_word(input logic [21:0] a, input logic [15:0] old,
      input logic [15:0] d, input logic [5:0] ctl);
    logic prot;
    prot = (a < 22'h002000 && !ctl[2]) || (a >= 22'h010000 && a <= 22'h017fff && !ctl[3]);
    return (ctl[5] && !prot) ? (old & d) : old;
  endfunction
  task automatic prog(input logic [21:0] a, input logic [15:0] d, input logic [5:0] ctl);
    logic [31:0] q;
    logic [15:0] exp;
    exp = expect_word(a, shadow.exists(a) ? shadow[a] : 16'hffff, d, ctl);
    shadow[a] = exp;
    flash_op(a, d, ctl);
    flash_op(a, 16'h0, 6'h17);
    wb(1'b0, fsg_pkg::REG_RDAT, 32'h0, q);
    check(q, {16'h0, exp}, "word after program");
    wb(1'b0, fsg_pkg::REG_STAT, 32'h0, q);
    check(32'(q[fsg_pkg::STAT_IND]), 32'(exp[7]), "indicator bit");
  endtask
  always @(posedge clock)
  begin
    cycles++;
    if (cycles == 30000)
    begin
      miscompares++;
      final_report();
    end
  end
  initial
  begin
    logic [31:0] q;
    repeat (12) @(posedge clock);
    rst <= 1'b0;
    wb(1'b0, fsg_pkg::REG_CTRL, 32'h0, q);
    check(q, fsg_pkg::CTRL_RESET_VAL, "control reset value");
    check(32'({wp_n, reset_n, hv}), 32'h6, "pins after reset");
    wb(1'b1, 8'h20, 32'hffff_ffff, q);
    wb(1'b0, 8'h20, 32'h0, q);
    check(q, 32'h0, "unmapped read");
    repeat (6) prog(22'h020000 + 22'($random(seed) & 32'hfffff), 16'($random(seed)), 6'h35);
    prog(22'h030000, 16'h1234, 6'h15);
    for (int i = 0; i < 4; i++)
    begin
      prog(22'h001ffc + 22'(i), 16'h5a80 ^ 16'(i), {2'b11, 2'(i), 2'b01});
      prog(22'h010000 + 22'(i), 16'h0f80 ^ 16'(i), {2'b11, 2'(i), 2'b01});
    end
    prog(22'h010002, 16'h0000, 6'h35);
    prog(22'h002000, 16'h00a5, 6'h31);
    wb(1'b1, fsg_pkg::REG_ADDR, 32'h0004_0000, q);
    wb(1'b1, fsg_pkg::REG_CTRL, 32'h35, q);
    wb(1'b1, fsg_pkg::REG_CTRL, 32'h35, q);
    wb(1'b0, fsg_pkg::REG_STAT, 32'h0, q);
    check(32'(q[fsg_pkg::STAT_REFUS]), 32'h1, "go while busy");
    // Let the accepted program finish before touching the address register again.
    do
    begin
      wb(1'b0, fsg_pkg::REG_STAT, 32'h0, q);
    end while (q[fsg_pkg::STAT_BUSY] !== 1'b0);
    flash_op(22'h040000, 16'h0, 6'h17);
    wb(1'b0, fsg_pkg::REG_RDAT, 32'h0, q);
    check(q, 32'h0, "first program survives refused go");
    wb(1'b1, fsg_pkg::REG_STAT, 32'h2, q);
    supply <= 1'b0;
    repeat (4) @(posedge clock);
    wb(1'b0, fsg_pkg::REG_STAT, 32'h0, q);
    check(32'(q[3:1]), 32'h0, "supply low, refusal cleared");
    wb(1'b1, fsg_pkg::REG_CTRL, 32'h35, q);
    wb(1'b0, fsg_pkg::REG_STAT, 32'h0, q);
    check(32'(q[fsg_pkg::STAT_REFUS]), 32'h1, "write with supply low");
    supply <= 1'b1;
    repeat (4) @(posedge clock);
    final_report();
  end
endmodule
